// ### core/ptc_pkg.sv
// Summary of operation
// - Prescaler advances every cycle clock except in standby hold, where it freezes.
// - Prescaler match pulse when count equals match value, period 1 to 256 cycles.
// - Prescaler restarts from zero on its match and on a match value write.
// - Low byte counts only while control bit 6 is set; cleared holds it zero.
// - High byte counts only while control bit 7 is set; cleared holds it zero.
// - Low byte clock: prescaler match if bit 4 clear, inputs 2 or 3 if set.
// - High byte clock: prescaler match if bit 5 clear; set chains a 16-bit counter.
// - Chained mode matches only when all 16 bits equal both match buffers.
// - Each counter byte returns to zero when stopped and on its own match.
// - Match buffer follows its register while stopped, reloads from it on match.
// - Low capture on inputs 0,2,4 with bit 5 clear; 1,3,4 with it set.
// - High capture takes the high count on inputs 1, 3 or 4.
// - High match flag bit 3 set on a running high match; never cleared by hardware.
// - Low match flag bit 1 set on a running low match; never cleared by hardware.
// - High interrupt request while bit 2 enable and high match flag are both set.
// - Low interrupt request while bit 0 enable and low match flag are both set.
// - Chained mode sets both match flags together on a full 16-bit match.
// - Counter bytes read back only; writes to them are ignored.
package ptc_pkg;

   // ------------------------------------------------------------
   // Register indices; byte address is four times the index
   // ------------------------------------------------------------
   localparam logic [15:0] IDX_TIMER_CONTROL = 16'hfe10;
   localparam logic [15:0] IDX_PRESCALER_MATCH_VALUE = 16'hfe11;
   localparam logic [15:0] IDX_LOW_BYTE_COUNT = 16'hfe12;
   localparam logic [15:0] IDX_HIGH_BYTE_COUNT = 16'hfe13;
   localparam logic [15:0] IDX_LOW_MATCH_VALUE = 16'hfe14;
   localparam logic [15:0] IDX_HIGH_MATCH_VALUE = 16'hfe15;
   localparam logic [15:0] IDX_LOW_CAPTURE = 16'hfe16;
   localparam logic [15:0] IDX_HIGH_CAPTURE = 16'hfe17;

   // ------------------------------------------------------------
   // Control register field positions
   // ------------------------------------------------------------
   localparam int CTL_LOW_IRQ_ENABLE = 0;
   localparam int CTL_LOW_MATCH_FLAG = 1;
   localparam int CTL_HIGH_IRQ_ENABLE = 2;
   localparam int CTL_HIGH_MATCH_FLAG = 3;
   localparam int CTL_LOW_EXTERNAL_CLOCK_SEL = 4;
   localparam int CTL_CHAIN_16BIT = 5;
   localparam int CTL_LOW_RUN = 6;
   localparam int CTL_HIGH_RUN = 7;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;
   localparam logic [7:0] RST_PRESCALER_MATCH_VALUE = 8'h00;
   localparam logic [7:0] RST_COUNT = 8'h00;
   localparam logic [7:0] RST_MATCH_VALUE = 8'h00;
   localparam logic [7:0] RST_CAPTURE = 8'h00;
   localparam logic [7:0] RST_PRESCALER = 8'h00;

   // ------------------------------------------------------------
   // Timing: prescaler steps once per cycle clock
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int TCYC_NS = 25;
   localparam int PRESCALE_STEP_CYCLES =
      (TCYC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ### core/ptc_timer.sv
`timescale 1ns/10ps
module ptc_timer #(
   parameter int ADDR_W = 18
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Detection pulses from the external pin logic, same clock
   input wire logic ext_detect_0,
   input wire logic ext_detect_1,
   input wire logic ext_detect_2,
   input wire logic ext_detect_3,
   input wire logic ext_detect_4,
   // Standby hold level from the power controller, same clock
   input wire logic standby_hold,
   // Interrupt requests
   output logic irq_low,
   output logic irq_high
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] presc;
      logic [7:0] ctrl;
      logic [7:0] prr;
      logic [7:0] cnt_l;
      logic [7:0] cnt_h;
      logic [7:0] lr;
      logic [7:0] hr;
      logic [7:0] buf_l;
      logic [7:0] buf_h;
      logic [7:0] cap_l;
      logic [7:0] cap_h;
      logic [7:0] rdata;
      logic ready;
      logic err;
      logic irq_l;
      logic irq_h;
   } ptc_state_s;

   ptc_state_s state_reg;
   ptc_state_s state_next;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   logic [15:0] idx;
   logic aligned;
   logic setup;
   logic done;
   logic wr_done;
   logic hit;
   logic [7:0] rd_mux;

   assign idx = 16'(paddr[ADDR_W-1:2]);
   assign aligned = (paddr[1:0] == 2'h0);
   assign setup = psel && !penable;
   assign done = psel && penable && state_reg.ready;
   assign wr_done = done && pwrite && !state_reg.err;

   always_comb
   begin
      hit = aligned;
      rd_mux = 8'h00;
      case (idx)
         ptc_pkg::IDX_TIMER_CONTROL: rd_mux = state_reg.ctrl;
         ptc_pkg::IDX_PRESCALER_MATCH_VALUE: rd_mux = state_reg.prr;
         ptc_pkg::IDX_LOW_BYTE_COUNT: rd_mux = state_reg.cnt_l;
         ptc_pkg::IDX_HIGH_BYTE_COUNT: rd_mux = state_reg.cnt_h;
         ptc_pkg::IDX_LOW_MATCH_VALUE: rd_mux = state_reg.lr;
         ptc_pkg::IDX_HIGH_MATCH_VALUE: rd_mux = state_reg.hr;
         ptc_pkg::IDX_LOW_CAPTURE: rd_mux = state_reg.cap_l;
         ptc_pkg::IDX_HIGH_CAPTURE: rd_mux = state_reg.cap_h;
         default: hit = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // Timer decode
   // ------------------------------------------------------------
   logic active;
   logic low_run;
   logic high_run;
   logic chain_16bit;
   logic low_external_clock_sel;
   logic presc_match;
   logic ext_count;
   logic low_tick;
   logic high_tick;
   logic low_match;
   logic high_match;
   logic full_match;
   logic [15:0] cnt16;
   logic [15:0] cnt16_inc;
   logic cap_low_evt;
   logic cap_high_evt;

   assign active = !standby_hold;
   assign low_run = state_reg.ctrl[ptc_pkg::CTL_LOW_RUN];
   assign high_run = state_reg.ctrl[ptc_pkg::CTL_HIGH_RUN];
   assign chain_16bit = state_reg.ctrl[ptc_pkg::CTL_CHAIN_16BIT];
   assign low_external_clock_sel =
      state_reg.ctrl[ptc_pkg::CTL_LOW_EXTERNAL_CLOCK_SEL];

   assign presc_match = active && (state_reg.presc == state_reg.prr);
   assign ext_count = active && (ext_detect_2 || ext_detect_3);
   // Low clock source, also the 16-bit source when chained
   assign low_tick = low_run &&
      (low_external_clock_sel ? ext_count : presc_match);
   assign high_tick = high_run && presc_match;

   assign cnt16 = {state_reg.cnt_h, state_reg.cnt_l};
   assign cnt16_inc = cnt16 + 16'h0001;
   // Full 16-bit compare against both buffers
   assign full_match = chain_16bit && low_tick &&
      (cnt16 == {state_reg.buf_h, state_reg.buf_l});
   assign low_match = chain_16bit ? full_match :
      (low_tick && (state_reg.cnt_l == state_reg.buf_l));
   assign high_match = chain_16bit ? full_match :
      (high_tick && (state_reg.cnt_h == state_reg.buf_h));

   assign cap_low_evt = active && (chain_16bit ?
      (ext_detect_1 || ext_detect_3 || ext_detect_4) :
      (ext_detect_0 || ext_detect_2 || ext_detect_4));
   assign cap_high_evt = active &&
      (ext_detect_1 || ext_detect_3 || ext_detect_4);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;

      // Bus: answer one cycle after setup, read data held from setup
      state_next.ready = 1'b0;
      state_next.err = 1'b0;
      if (setup)
      begin
         state_next.ready = 1'b1;
         state_next.err = !hit;
         state_next.rdata = hit ? rd_mux : 8'h00;
      end

      // Software writes; count and capture registers ignore them
      if (wr_done)
      begin
         case (idx)
            ptc_pkg::IDX_TIMER_CONTROL: state_next.ctrl = pwdata[7:0];
            ptc_pkg::IDX_PRESCALER_MATCH_VALUE: state_next.prr = pwdata[7:0];
            ptc_pkg::IDX_LOW_MATCH_VALUE: state_next.lr = pwdata[7:0];
            ptc_pkg::IDX_HIGH_MATCH_VALUE: state_next.hr = pwdata[7:0];
            default: state_next.ctrl = state_reg.ctrl;
         endcase
      end

      // Prescaler
      if (wr_done && (idx == ptc_pkg::IDX_PRESCALER_MATCH_VALUE))
         state_next.presc = ptc_pkg::RST_PRESCALER;
      else if (presc_match)
         state_next.presc = ptc_pkg::RST_PRESCALER;
      else if (active)
         state_next.presc = state_reg.presc + 8'h01;

      // Low byte counter
      if (!low_run)
         state_next.cnt_l = ptc_pkg::RST_COUNT;
      else if (low_match)
         state_next.cnt_l = ptc_pkg::RST_COUNT;
      else if (low_tick)
         state_next.cnt_l = cnt16_inc[7:0];

      // High byte counter; chained it counts low byte overflows
      if (!high_run)
         state_next.cnt_h = ptc_pkg::RST_COUNT;
      else if (high_match)
         state_next.cnt_h = ptc_pkg::RST_COUNT;
      else if (chain_16bit ? low_tick : high_tick)
         state_next.cnt_h = chain_16bit ?
            cnt16_inc[15:8] : state_reg.cnt_h + 8'h01;

      // Match buffers use the register value before this write lands
      if (!low_run || low_match)
         state_next.buf_l = state_reg.lr;
      if (!high_run || high_match)
         state_next.buf_h = state_reg.hr;

      // Flags: a hardware set beats a software clear in the same cycle
      if (low_match)
         state_next.ctrl[ptc_pkg::CTL_LOW_MATCH_FLAG] = 1'b1;
      if (high_match)
         state_next.ctrl[ptc_pkg::CTL_HIGH_MATCH_FLAG] = 1'b1;

      // Captures snapshot the counts before this cycle's step
      if (cap_low_evt)
         state_next.cap_l = state_reg.cnt_l;
      if (cap_high_evt)
         state_next.cap_h = state_reg.cnt_h;

      // Requests follow the flags with one cycle of register delay
      state_next.irq_l = state_reg.ctrl[ptc_pkg::CTL_LOW_IRQ_ENABLE] &&
         state_reg.ctrl[ptc_pkg::CTL_LOW_MATCH_FLAG];
      state_next.irq_h = state_reg.ctrl[ptc_pkg::CTL_HIGH_IRQ_ENABLE] &&
         state_reg.ctrl[ptc_pkg::CTL_HIGH_MATCH_FLAG];
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg.presc <= ptc_pkg::RST_PRESCALER;
         state_reg.ctrl <= ptc_pkg::RST_TIMER_CONTROL;
         state_reg.prr <= ptc_pkg::RST_PRESCALER_MATCH_VALUE;
         state_reg.cnt_l <= ptc_pkg::RST_COUNT;
         state_reg.cnt_h <= ptc_pkg::RST_COUNT;
         state_reg.lr <= ptc_pkg::RST_MATCH_VALUE;
         state_reg.hr <= ptc_pkg::RST_MATCH_VALUE;
         state_reg.buf_l <= ptc_pkg::RST_MATCH_VALUE;
         state_reg.buf_h <= ptc_pkg::RST_MATCH_VALUE;
         state_reg.cap_l <= ptc_pkg::RST_CAPTURE;
         state_reg.cap_h <= ptc_pkg::RST_CAPTURE;
         state_reg.rdata <= 8'h00;
         state_reg.ready <= 1'b0;
         state_reg.err <= 1'b0;
         state_reg.irq_l <= 1'b0;
         state_reg.irq_h <= 1'b0;
      end
      else
         state_reg <= state_next;
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign prdata = {24'h000000, state_reg.rdata};
   assign pready = state_reg.ready;
   assign pslverr = state_reg.err;
   assign irq_low = state_reg.irq_l;
   assign irq_high = state_reg.irq_h;

endmodule // ptc_timer

// ### test/ptc_detect_model.sv
`timescale 1ns/10ps
module ptc_detect_model (
   // Clock
   input wire logic pclk,
   // Pin detection pulses and hold level
   output logic [4:0] detect,
   output logic hold
);
   initial
   begin
      detect = 5'h00;
      hold = 1'b0;
   end
   // A gap after each pulse, as real edge logic never fires twice in a row
   task pulse(input int n, input int k);
      repeat (k)
      begin
         @(posedge pclk);
         detect <= 5'h01 << n;
         @(posedge pclk);
         detect <= 5'h00;
      end
   endtask
   task set_hold(input logic v);
      @(posedge pclk);
      hold <= v;
   endtask
endmodule // ptc_detect_model

// ### test/ptc_timer_assertions.sv
`timescale 1ns/10ps
module ptc_timer_assertions #(
   parameter int ADDR_W = 18
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Interrupts
   input wire logic irq_low,
   input wire logic irq_high
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire acc = psel && penable && pready;
   // Control data is the setup-cycle value, the one irq was built from
   wire crd = acc && !pwrite && !pslverr
      && paddr == ADDR_W'({ptc_pkg::IDX_TIMER_CONTROL, 2'b00});
   property p_rdy;
      psel && !penable |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("ready late");
   property p_acc;
      pready |-> psel && penable; endproperty
   a_acc: assert property (p_acc) else $error("ready outside access");
   property p_err;
      acc && paddr[1:0] != 2'b00 |-> pslverr && prdata == 32'h0; endproperty
   a_err: assert property (p_err) else $error("unaligned not refused");
   property p_top;
      pready |-> prdata[31:8] == 24'h0; endproperty
   a_top: assert property (p_top) else $error("upper read bits set");
   property p_il;
      crd |-> irq_low == (prdata[0] && prdata[1]); endproperty
   a_il: assert property (p_il) else $error("irq_low wrong");
   property p_ih;
      crd |-> irq_high == (prdata[2] && prdata[3]); endproperty
   a_ih: assert property (p_ih) else $error("irq_high wrong");
   property p_lf;
      $fell(irq_low) |-> $past(acc && pwrite, 2); endproperty
   a_lf: assert property (p_lf) else $error("low flag lost");
   property p_hf;
      $fell(irq_high) |-> $past(acc && pwrite, 2); endproperty
   a_hf: assert property (p_hf) else $error("high flag lost");
   c_il: cover property ($rose(irq_low));
   c_ih: cover property ($rose(irq_high));
   c_err: cover property (pslverr);
endmodule // ptc_timer_assertions

bind ptc_timer ptc_timer_assertions #(.ADDR_W(ADDR_W))
   ptc_timer_assertions_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .irq_low(irq_low), .irq_high(irq_high));

// ### test/ptc_timer_bench.sv
`timescale 1ns/10ps
module ptc_timer_bench;
   localparam logic [15:0] CTL = ptc_pkg::IDX_TIMER_CONTROL;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [17:0] paddr = 18'h0;
   logic [31:0] pwdata = 32'h0;
   logic [1:0] boff = 2'b00;
   logic [31:0] prdata, rdat;
   logic pready, pslverr, irq_low, irq_high, hold, rerr;
   logic [4:0] det;
   int miscompares = 0;
   int checks = 0;
   int cycles = 0;
   always #12.5 pclk = ~pclk;
   ptc_timer ptc_timer_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_detect_0(det[0]),
      .ext_detect_1(det[1]), .ext_detect_2(det[2]), .ext_detect_3(det[3]),
      .ext_detect_4(det[4]), .standby_hold(hold), .irq_low(irq_low),
      .irq_high(irq_high));
   ptc_detect_model ptc_detect_model_inst (
      .pclk(pclk), .detect(det), .hold(hold));
   task final_report;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Index i is relative to the control register; 8 is unmapped
   task apb(input logic wr, input logic [3:0] i, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {CTL + {12'h0, i}, boff};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input logic [3:0] i, input logic [31:0] exp);
      apb(1'b0, i, 8'h00);
      chk(rdat, exp);
   endtask
   task p(input int n, input int k);
      ptc_detect_model_inst.pulse(n, k);
   endtask
   always @(posedge pclk)
   begin
      if (++cycles == 5000)
      begin
         miscompares++;
         final_report();
      end
   end
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd(4'h0, 32'h0);
      rd(4'h8, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      boff = 2'b01;
      rd(4'h0, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      boff = 2'b00;
      $display("test reset done");
      apb(1'b1, 4'h4, 8'h10);
      apb(1'b1, 4'h0, 8'h50);
      p(2, 2);
      p(3, 1);
      rd(4'h2, 32'h3);
      p(0, 1);
      p(2, 1);
      p(1, 1);
      rd(4'h6, 32'h3);
      p(4, 1);
      rd(4'h6, 32'h4);
      apb(1'b1, 4'h2, 8'h77);
      ptc_detect_model_inst.set_hold(1'b1);
      p(2, 1);
      ptc_detect_model_inst.set_hold(1'b0);
      rd(4'h2, 32'h4);
      apb(1'b1, 4'h0, 8'h10);
      rd(4'h2, 32'h0);
      $display("test event count done");
      apb(1'b1, 4'h4, 8'h02);
      apb(1'b1, 4'h0, 8'h51);
      p(2, 3);
      rd(4'h0, 32'h53);
      chk({31'h0, irq_low}, 32'h1);
      apb(1'b1, 4'h0, 8'h51);
      apb(1'b1, 4'h4, 8'h05);
      p(2, 3);
      rd(4'h0, 32'h53);
      apb(1'b1, 4'h0, 8'h00);
      $display("test match done");
      apb(1'b1, 4'h4, 8'h01);
      apb(1'b1, 4'h5, 8'h01);
      apb(1'b1, 4'h0, 8'hf4);
      p(2, 256);
      rd(4'h3, 32'h1);
      p(3, 1);
      p(1, 1);
      rd(4'h6, 32'h1);
      rd(4'h7, 32'h1);
      rd(4'h0, 32'hf4);
      p(2, 1);
      rd(4'h0, 32'hfe);
      rd(4'h3, 32'h0);
      chk({31'h0, irq_high}, 32'h1);
      apb(1'b1, 4'h0, 8'h00);
      $display("test chained done");
      // Both bytes start together, so sixteen cycles apart differ by four
      apb(1'b1, 4'h1, 8'h03);
      apb(1'b1, 4'h4, 8'hff);
      apb(1'b1, 4'h5, 8'hff);
      apb(1'b1, 4'h0, 8'hc0);
      p(0, 1);
      repeat (14) @(posedge pclk);
      p(1, 1);
      rd(4'h6, 32'h0);
      rd(4'h7, 32'h4);
      $display("test prescaler done");
      final_report();
   end
endmodule // ptc_timer_bench
